// ==== rtl/iro_output_regs.sv ====
// Read-only rate and acceleration output register set with a byte-addressed read port.
`default_nettype none
module iro_output_regs (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic sample_valid_i,
    input wire logic [31:0] rate_x_i,
    input wire logic [31:0] rate_y_i,
    input wire logic [31:0] rate_z_i,
    input wire logic [31:0] accel_x_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [6:0] addr_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    output logic err_o
);
    logic [3:0][31:0] sample_w;
    logic [3:0][15:0] word_w;
    logic [3:0][15:0] fraction_w;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic err_q;
    logic err_d;
    logic hit_w;

    assign sample_w = {accel_x_i, rate_z_i, rate_y_i, rate_x_i};

    // Every axis shares one load strobe, so all four pairs come from the same sample.
    for (genvar g = 0; g < iro_pkg::IRO_AXES; g++) begin : g_axis
        iro_axis_store u_store (
            .clock_i(clock_i),
            .srst_i(srst_i),
            .load_i(sample_valid_i),
            .sample_i(sample_w[g]),
            .word_o(word_w[g]),
            .fraction_o(fraction_w[g])
        );
    end

    // Decode a byte address to an axis index; either byte of a register selects it.
    function automatic logic [1:0] axis_of(input logic [6:0] a);
        logic [6:0] t;
        t = a - iro_pkg::IRO_RATE_X_FRACTION;
        axis_of = t[3:2];
    endfunction

    function automatic logic in_map(input logic [6:0] a);
        in_map = (a >= iro_pkg::IRO_MAP_FIRST) && (a <= iro_pkg::IRO_MAP_LAST);
    endfunction

    assign hit_w = in_map(addr_i);

    always_comb begin
        rdata_d = iro_pkg::IRO_ZERO_WORD;
        err_d = 1'b0;
        if (wr_i) begin
            err_d = 1'b1;
        end else if (rd_i && !hit_w) begin
            err_d = 1'b1;
        end else if (rd_i) begin
            // Bit 1 of the byte address picks the high word over the fraction.
            if (addr_i[1]) begin
                rdata_d = word_w[axis_of(addr_i)];
            end else begin
                rdata_d = fraction_w[axis_of(addr_i)];
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_q <= iro_pkg::IRO_ZERO_WORD;
        end else if (rd_i) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rvalid_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rvalid_q <= rd_i && !wr_i;
            err_q <= err_d;
        end
    end

    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign err_o = err_q;

    property p_read_latency;
        @(posedge clock_i) disable iff (srst_i) rd_i && !wr_i |=> rvalid_o;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read answer missing");
    property p_write_refused;
        @(posedge clock_i) disable iff (srst_i)
        wr_i && !sample_valid_i |=> err_o && $stable(word_w);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("write not refused");
    property p_rate_x_word;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_X_WORD |=> rdata_o == $past(word_w[0]);
    endproperty
    a_rate_x_word: assert property (p_rate_x_word) else $error("rate x word wrong");
    property p_rate_z_frac;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_Z_FRACTION
        |=> rdata_o == $past(fraction_w[2]);
    endproperty
    a_rate_z_frac: assert property (p_rate_z_frac) else $error("rate z fraction wrong");
    property p_accel_word;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_ACCEL_X_WORD |=> rdata_o == $past(word_w[3]);
    endproperty
    a_accel_word: assert property (p_accel_word) else $error("accel x word wrong");
    property p_accel_join;
        @(posedge clock_i) disable iff (srst_i)
        sample_valid_i ##1 !sample_valid_i |-> {word_w[3], fraction_w[3]} == $past(accel_x_i);
    endproperty
    a_accel_join: assert property (p_accel_join) else $error("accel pair not 32-bit value");
    property p_rate_sign;
        @(posedge clock_i) disable iff (srst_i)
        sample_valid_i && rate_y_i[31] |=> word_w[1][15];
    endproperty
    a_rate_sign: assert property (p_rate_sign) else $error("rate sign lost");
    property p_accel_zero;
        @(posedge clock_i) disable iff (srst_i)
        sample_valid_i && accel_x_i[31:16] == 16'h0000 |=> word_w[3] == iro_pkg::IRO_ZERO_WORD;
    endproperty
    a_accel_zero: assert property (p_accel_zero) else $error("zero accel not 0x0000");
    property p_unmapped;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && !in_map(addr_i) |=> err_o && rdata_o == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");

    // Every register of the map is checked on its own, odd bytes of the rate x and accel x high words included.
    property p_rate_x_frac;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_X_FRACTION
        |=> rdata_o == $past(fraction_w[0]);
    endproperty
    a_rate_x_frac: assert property (p_rate_x_frac) else $error("rate x fraction wrong");

    property p_rate_x_odd;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_X_WORD + 7'h01
        |=> rdata_o == $past(word_w[0]);
    endproperty
    a_rate_x_odd: assert property (p_rate_x_odd) else $error("rate x odd byte wrong");

    property p_rate_y_frac;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_Y_FRACTION
        |=> rdata_o == $past(fraction_w[1]);
    endproperty
    a_rate_y_frac: assert property (p_rate_y_frac) else $error("rate y fraction wrong");

    property p_rate_y_word;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_Y_WORD
        |=> rdata_o == $past(word_w[1]);
    endproperty
    a_rate_y_word: assert property (p_rate_y_word) else $error("rate y word wrong");

    property p_rate_z_word;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_RATE_Z_WORD
        |=> rdata_o == $past(word_w[2]);
    endproperty
    a_rate_z_word: assert property (p_rate_z_word) else $error("rate z word wrong");

    property p_accel_frac;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_ACCEL_X_FRACTION
        |=> rdata_o == $past(fraction_w[3]);
    endproperty
    a_accel_frac: assert property (p_accel_frac) else $error("accel x fraction wrong");

    property p_accel_odd;
        @(posedge clock_i) disable iff (srst_i)
        rd_i && !wr_i && addr_i == iro_pkg::IRO_ACCEL_X_WORD + 7'h01
        |=> rdata_o == $past(word_w[3]);
    endproperty
    a_accel_odd: assert property (p_accel_odd) else $error("accel x odd byte wrong");

    property p_rate_join;
        @(posedge clock_i) disable iff (srst_i)
        sample_valid_i ##1 !sample_valid_i
        |-> {word_w[0], fraction_w[0]} == $past(rate_x_i);
    endproperty
    a_rate_join: assert property (p_rate_join) else $error("rate pair not one sample");

    property p_accel_sign;
        @(posedge clock_i) disable iff (srst_i)
        sample_valid_i && accel_x_i[31] |=> word_w[3][15];
    endproperty
    a_accel_sign: assert property (p_accel_sign) else $error("accel sign lost");

    // The answer flags stand one cycle for each cycle of request, so a host can count them.
    property p_rvalid_pulse;
        @(posedge clock_i) disable iff (srst_i)
        !rd_i |=> !rvalid_o;
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read answer without read");

    property p_err_quiet;
        @(posedge clock_i) disable iff (srst_i)
        !wr_i && !(rd_i && !in_map(addr_i)) |=> !err_o;
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("error without cause");

    property p_rdata_hold;
        @(posedge clock_i) disable iff (srst_i)
        !rd_i |=> $stable(rdata_o);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

    property p_write_frac;
        @(posedge clock_i) disable iff (srst_i)
        wr_i && !sample_valid_i |=> $stable(fraction_w);
    endproperty
    a_write_frac: assert property (p_write_frac) else $error("write changed a fraction");

    property p_reset_outs;
        @(posedge clock_i)
        srst_i |=> rdata_o == iro_pkg::IRO_ZERO_WORD && !rvalid_o && !err_o;
    endproperty
    a_reset_outs: assert property (p_reset_outs) else $error("outputs not cleared by reset");

    c_read_word: cover property (@(posedge clock_i) rd_i && addr_i[1] ##1 rvalid_o);
    c_read_frac: cover property (@(posedge clock_i) rd_i && !addr_i[1] ##1 rvalid_o);
    c_pair_read: cover property (@(posedge clock_i)
        rd_i && addr_i == iro_pkg::IRO_ACCEL_X_FRACTION
        ##4 rd_i && addr_i == iro_pkg::IRO_ACCEL_X_WORD);
    c_update: cover property (@(posedge clock_i) sample_valid_i ##2 rd_i);
endmodule
`default_nettype wire

// ==== rtl/iro_pkg.sv ====
// Package with the register map, field layout and timing constants of the inertial output registers.
// Summary of operation
// - Each acceleration axis has a high and a low word that join into one 32-bit twos complement value.
// - Each rate high word is a 16-bit twos complement value, zero rotation reads 0x0000, one step is the rate scale factor.
// - Each acceleration high word is 16-bit twos complement, zero reads 0x0000, one step is 2.45 mm/sec2 over +/-78.4 m/sec2.
// - Each low word holds 16 further fraction bits below the matching high word's lowest bit.
// - Rate words sit at byte addresses 0x04/0x06 (x), 0x08/0x0A (y), 0x0C/0x0E (z), each over two bytes.
// - The x acceleration low word sits at 0x10/0x11 and its high word at 0x12/0x13.
// - The output registers are read-only, have no default and are never kept in backup storage.
// - The rate scale factor per step is 0.00625, 0.025 or 0.1 deg/sec for the 125, 500 or 2000 deg/sec models.
`default_nettype none
package iro_pkg;
    localparam int unsigned IRO_ADDR_W = 7;
    localparam int unsigned IRO_WORD_W = 16;
    localparam int unsigned IRO_AXES = 4;
    localparam logic [6:0] IRO_RATE_X_FRACTION = 7'h04;
    localparam logic [6:0] IRO_RATE_X_WORD = 7'h06;
    localparam logic [6:0] IRO_RATE_Y_FRACTION = 7'h08;
    localparam logic [6:0] IRO_RATE_Y_WORD = 7'h0a;
    localparam logic [6:0] IRO_RATE_Z_FRACTION = 7'h0c;
    localparam logic [6:0] IRO_RATE_Z_WORD = 7'h0e;
    localparam logic [6:0] IRO_ACCEL_X_FRACTION = 7'h10;
    localparam logic [6:0] IRO_ACCEL_X_WORD = 7'h12;
    localparam logic [6:0] IRO_MAP_FIRST = 7'h04;
    localparam logic [6:0] IRO_MAP_LAST = 7'h13;
    localparam logic [15:0] IRO_ZERO_WORD = 16'h0000;
    localparam logic [15:0] IRO_ACCEL_POS_FULL = 16'h7d00;
    localparam logic [15:0] IRO_ACCEL_NEG_FULL = 16'h8300;
    // Rate scale per step in micro deg/sec, one per model range.
    localparam int unsigned IRO_RATE_SCALE_125_UDPS = 6250;
    localparam int unsigned IRO_RATE_SCALE_500_UDPS = 25000;
    localparam int unsigned IRO_RATE_SCALE_2000_UDPS = 100000;
    localparam int unsigned IRO_ACCEL_STEP_UMPS2 = 2450;
    localparam int unsigned IRO_READ_LATENCY = 1;
    typedef enum logic [1:0] {IRO_RANGE_125, IRO_RANGE_500, IRO_RANGE_2000} iro_range_t;
endpackage
`default_nettype wire

// ==== rtl/iro_axis_store.sv ====
// One axis pair store: high word and fraction word loaded together from one sample.
`default_nettype none
module iro_axis_store (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic load_i,
    input wire logic [31:0] sample_i,
    output logic [15:0] word_o,
    output logic [15:0] fraction_o
);
    logic [15:0] word_q;
    logic [15:0] fraction_q;

    // Both halves load on the same edge, so no read sees a torn pair.
    always_ff @(posedge clock_i) begin
        if (load_i) begin
            word_q <= sample_i[31:16];
            fraction_q <= sample_i[15:0];
        end
    end
    // No reset clears the data: the registers have no defined default.
    assign word_o = word_q;
    assign fraction_o = fraction_q;

    property p_pair_load;
        @(posedge clock_i) disable iff (srst_i)
        load_i |=> {word_q, fraction_q} == $past(sample_i);
    endproperty
    a_pair_load: assert property (p_pair_load) else $error("axis pair load torn");
    property p_pair_hold;
        @(posedge clock_i) disable iff (srst_i)
        !load_i |=> $stable(word_q) && $stable(fraction_q);
    endproperty
    a_pair_hold: assert property (p_pair_hold) else $error("axis pair changed without a load");
endmodule
`default_nettype wire

// ==== tb/iro_host_model.sv ====
// Host model that issues single register reads and writes on the byte-addressed port.
`default_nettype none
module iro_host_model (
    input wire logic clock_i,
    output logic rd_o,
    output logic wr_o,
    output logic [6:0] addr_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 7'h00;
    end
    // One request held for one rising edge; the answer is settled when the task returns.
    task automatic access(input logic [6:0] addr, input logic write);
        @(negedge clock_i);
        rd_o = !write;
        wr_o = write;
        addr_o = addr;
        @(negedge clock_i);
        rd_o = 1'b0;
        wr_o = 1'b0;
        // A released address flips, so a design that ignores the strobe cannot pass.
        addr_o = ~addr;
    endtask
endmodule
`default_nettype wire

// ==== tb/iro_output_regs_tb_top.sv ====
// Self-checking bench for the inertial output register set.
`default_nettype none
module iro_output_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic sample_valid_i = 1'b1;
    logic [31:0] smp [4];
    logic [31:0] din [4];
    logic rd, wr, rvalid_o, err_o;
    logic [6:0] addr;
    logic [15:0] rdata_o;
    int miscompares = 0;
    int n_checks = 0;
    always #25 clock_i = ~clock_i;
    iro_output_regs u_dut (.clock_i(clock_i), .srst_i(srst_i), .sample_valid_i(sample_valid_i),
        .rate_x_i(din[0]), .rate_y_i(din[1]), .rate_z_i(din[2]), .accel_x_i(din[3]),
        .rd_i(rd), .wr_i(wr), .addr_i(addr), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .err_o(err_o));
    iro_host_model u_host (.clock_i(clock_i), .rd_o(rd), .wr_o(wr), .addr_o(addr));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Inputs are inverted after the load so that only stored values can match.
    task automatic load_and_read(input logic [31:0] s0, s1, s2, s3);
        smp = '{s0, s1, s2, s3};
        @(negedge clock_i);
        din = smp;
        sample_valid_i = 1'b1;
        @(negedge clock_i);
        sample_valid_i = 1'b0;
        foreach (din[i]) din[i] = ~smp[i];
        for (int i = 0; i < 4; i++) begin
            for (int b = 0; b < 4; b++) begin
                u_host.access(7'(4 + 4 * i + b), 1'b0);
                if (b < 2) begin
                    check("rdata lo", 32'(rdata_o), 32'(smp[i][15:0]));
                end else begin
                    check("rdata hi", 32'(rdata_o), 32'(smp[i][31:16]));
                end
                check("flags", 32'({rvalid_o, err_o}), 32'h0000_0002);
            end
        end
    endtask
    task automatic refusals();
        logic [6:0] bad [3] = '{7'h03, 7'h14, 7'h7f};
        foreach (bad[k]) begin
            u_host.access(bad[k], 1'b0);
            check("bad rdata", 32'(rdata_o), 32'h0000_0000);
            check("bad flags", 32'({rvalid_o, err_o}), 32'h0000_0003);
        end
        u_host.access(7'h12, 1'b1);
        check("wr flags", 32'({rvalid_o, err_o}), 32'h0000_0001);
        u_host.access(7'h12, 1'b0);
        check("after wr", 32'(rdata_o), 32'(smp[3][31:16]));
    endtask
    task automatic reset_mid();
        u_host.access(7'h06, 1'b0);
        check("pre rst", 32'(rdata_o), 32'(smp[0][31:16]));
        srst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        check("rst outs", 32'({rdata_o, rvalid_o, err_o}), 32'h0000_0000);
        srst_i = 1'b0;
        // Data registers keep their contents through reset; only the read port clears.
        u_host.access(7'h06, 1'b0);
        check("post rst", 32'(rdata_o), 32'(smp[0][31:16]));
        check("post flags", 32'({rvalid_o, err_o}), 32'h0000_0002);
    endtask
    initial begin
        foreach (din[i]) din[i] = 32'h0000_0000;
        // Samples load during reset so that the pair stores never hold unknowns.
        repeat (10) @(negedge clock_i);
        srst_i = 1'b0;
        sample_valid_i = 1'b0;
        check("idle", 32'({rvalid_o, err_o}), 32'h0000_0000);
        load_and_read(32'hffff_fffe, 32'h0000_0001, 32'h4e20_0000, 32'h7d00_ffff);
        refusals();
        load_and_read(32'h0000_0000, 32'hb1e0_0000, 32'h0001_8000, 32'h8300_0000);
        load_and_read(32'h0002_8000, 32'hffff_ffff, 32'hfffe_0002, 32'h0000_0001);
        reset_mid();
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge clock_i);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
